// ==== rtl/wtu_defs.svh ====
// Purpose: constants of the watchdog timeout unit
// Assumes: pclk at 40 MHz, one APB slave
// Notes: offsets are byte addresses of aligned 32-bit words
`ifndef WTU_DEFS_SVH
`define WTU_DEFS_SVH

`define WTU_CTRL_OFS 12'h000
`define WTU_STAT_OFS 12'h004
`define WTU_IRQ_OFS 12'h008
`define WTU_MASK_OFS 12'h00C
`define WTU_COUNT_OFS 12'h010

// control: bit0 software enable, bits 5:1 prescale select
`define WTU_CTRL_SWEN_BIT 0
`define WTU_CTRL_PS_LSB 1
`define WTU_PS_W 5
// selection 11 gives 2^11 ms = 2 s; 0 gives 1 ms, 18 gives 256 s
`define WTU_PS_RESET 5'h0B
`define WTU_PS_MAX 5'h12

// status: bit0 timeout flag (low = timed out), bit1 power-down flag, bit2 watchdog reset indicator (low = event)
`define WTU_STAT_TO_BIT 0
`define WTU_STAT_PWDN_BIT 1
`define WTU_STAT_WDRI_BIT 2

// interrupt status/mask: bit0 timeout while awake, bit1 timeout in sleep
`define WTU_IRQ_W 2

`define WTU_CLK_HZ 40000000
`define WTU_UNIT_NS 1000000
`define WTU_CNT_W 19
`define WTU_RST_PULSE_CYC 4'h8

`endif

// ==== rtl/wtu_pkg.sv ====
// Purpose: types of the watchdog timeout unit
// Assumes: nothing beyond the defs header
// Notes: no constants live here
package wtu_pkg;

  typedef enum logic [1:0] {
    WTU_MODE_OFF,
    WTU_MODE_SW,
    WTU_MODE_AWAKE,
    WTU_MODE_ON
  } wtu_mode_t;

  typedef struct packed {
    logic clear_instr;
    logic osc_fail;
    logic startup_running;
    logic sleeping;
  } wtu_core_evt_t;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic watchdog_reset_indicator;
  } wtu_status_t;

endpackage

// ==== rtl/wtu_ms_tick.sv ====
// Purpose: divides the low-frequency oscillator tick into 1 ms units
// Assumes: osc_tick is a one-pclk pulse per oscillator period
// Notes: clr restarts the partial unit so a fresh count is a whole unit
`timescale 1ns/1ps
module wtu_ms_tick #(
  parameter int TICKS_PER_MS = 31
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_tick,
  input wire logic clr,
  output logic ms_tick
);
  logic [5:0] div_reg;
  logic [5:0] div_next;
  logic ms_next;

  always_comb
  begin
    div_next = div_reg;
    ms_next = 1'b0;
    if (clr)
      div_next = 6'h00;
    else if (osc_tick)
    begin
      if (div_reg == 6'(TICKS_PER_MS - 1))
      begin
        div_next = 6'h00;
        ms_next = 1'b1;
      end
      else
        div_next = div_reg + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= 6'h00;
      ms_tick <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      ms_tick <= ms_next;
    end
  end
endmodule // wtu_ms_tick

// ==== rtl/wtu_top.sv ====
// Purpose: watchdog timeout unit with APB registers
// Assumes: core strobes are synchronous to pclk; osc_tick pulses at the ~31 kHz rate
// Notes: the APB slave answers with pready high in the access cycle, no wait states
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "wtu_defs.svh"
module wtu_top #(
  parameter int TICKS_PER_MS = 31
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] watchdog_mode_config,
  input wire logic osc_tick,
  input wire wtu_pkg::wtu_core_evt_t core_evt,
  output logic reset_req,
  output logic wake_req,
  output logic irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  wtu_pkg::wtu_mode_t mode;
  logic swen_reg, swen_next;
  logic [`WTU_PS_W-1:0] ps_reg, ps_next;
  logic [`WTU_CNT_W-1:0] cnt_reg, cnt_next;
  wtu_pkg::wtu_status_t stat_reg, stat_next;
  logic [`WTU_IRQ_W-1:0] ists_reg, ists_next, imask_reg, imask_next;
  logic sleep_d_reg;
  logic active, clear_cnt, ms_tick, timeout;
  logic [3:0] rst_cnt_reg, rst_cnt_next;
  logic wake_next, irq_next;
  logic [31:0] rdata_next;
  logic wr_acc, rd_acc, mapped, err_next;
  logic [`WTU_CNT_W-1:0] limit;

  assign mode = wtu_pkg::wtu_mode_t'(watchdog_mode_config);

  // ----------------------------------------
  // enable decode
  // ----------------------------------------
  always_comb
  begin
    case (mode)
      wtu_pkg::WTU_MODE_ON: active = 1'b1;
      wtu_pkg::WTU_MODE_AWAKE: active = !core_evt.sleeping;
      wtu_pkg::WTU_MODE_SW: active = swen_reg;
      wtu_pkg::WTU_MODE_OFF: active = 1'b0;
      default: active = 1'b0;
    endcase
  end

  // sleep edges in both directions clear; start-up timer holds clear after wake
  assign clear_cnt = core_evt.clear_instr || (core_evt.sleeping != sleep_d_reg)
    || core_evt.osc_fail || !active || core_evt.startup_running;

  wtu_ms_tick #(.TICKS_PER_MS(TICKS_PER_MS)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .osc_tick(osc_tick),
    .clr(clear_cnt),
    .ms_tick(ms_tick)
  );

  // selection s times out after 2^s ms; out-of-range selections saturate at 256 s
  assign limit = (ps_reg > `WTU_PS_MAX) ? (`WTU_CNT_W'(1) << `WTU_PS_MAX)
    : (`WTU_CNT_W'(1) << ps_reg);
  assign timeout = !clear_cnt && ms_tick && (cnt_reg == limit - `WTU_CNT_W'(1));

  // ----------------------------------------
  // counter and timeout
  // ----------------------------------------
  always_comb
  begin
    cnt_next = cnt_reg;
    stat_next = stat_reg;
    wake_next = 1'b0;
    rst_cnt_next = (rst_cnt_reg != 4'h0) ? rst_cnt_reg - 4'h1 : 4'h0;
    if (clear_cnt)
      cnt_next = '0;
    else if (timeout)
      cnt_next = '0;
    else if (ms_tick)
      cnt_next = cnt_reg + `WTU_CNT_W'(1);
    if (core_evt.sleeping && !sleep_d_reg)
      stat_next.powerdown_flag = 1'b0;
    if (core_evt.clear_instr)
    begin
      stat_next.timeout_flag = 1'b1;
      stat_next.powerdown_flag = 1'b1;
    end
    if (timeout)
    begin
      stat_next.timeout_flag = 1'b0;
      stat_next.powerdown_flag = !core_evt.sleeping;
      stat_next.watchdog_reset_indicator = 1'b0;
      if (core_evt.sleeping)
        wake_next = 1'b1;
      else
        rst_cnt_next = `WTU_RST_PULSE_CYC;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign mapped = (paddr == `WTU_CTRL_OFS) || (paddr == `WTU_STAT_OFS) || (paddr == `WTU_IRQ_OFS)
    || (paddr == `WTU_MASK_OFS) || (paddr == `WTU_COUNT_OFS);

  always_comb
  begin
    swen_next = swen_reg;
    ps_next = ps_reg;
    imask_next = imask_reg;
    ists_next = ists_reg;
    rdata_next = prdata;
    err_next = 1'b0;
    if (wr_acc && paddr == `WTU_CTRL_OFS)
    begin
      swen_next = pwdata[`WTU_CTRL_SWEN_BIT];
      ps_next = pwdata[`WTU_CTRL_PS_LSB +: `WTU_PS_W];
    end
    if (wr_acc && paddr == `WTU_MASK_OFS)
      imask_next = pwdata[`WTU_IRQ_W-1:0];
    if (wr_acc && paddr == `WTU_IRQ_OFS)
      ists_next = ists_reg & ~pwdata[`WTU_IRQ_W-1:0];
    // set wins over a clear in the same cycle
    ists_next = ists_next | {timeout && core_evt.sleeping, timeout && !core_evt.sleeping};
    irq_next = |(ists_next & imask_next);
    if (psel && !penable)
      err_next = !mapped;
    if (rd_acc)
    begin
      case (paddr)
        `WTU_CTRL_OFS: rdata_next = {26'h0, ps_reg, swen_reg};
        `WTU_STAT_OFS: rdata_next = {29'h0, stat_reg.watchdog_reset_indicator,
          stat_reg.powerdown_flag, stat_reg.timeout_flag};
        `WTU_IRQ_OFS: rdata_next = {30'h0, ists_reg};
        `WTU_MASK_OFS: rdata_next = {30'h0, imask_reg};
        `WTU_COUNT_OFS: rdata_next = {13'h0, cnt_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      swen_reg <= 1'b0;
      ps_reg <= `WTU_PS_RESET;
      cnt_reg <= '0;
      stat_reg <= 3'b111;
      ists_reg <= '0;
      imask_reg <= '0;
      sleep_d_reg <= 1'b0;
      rst_cnt_reg <= 4'h0;
      reset_req <= 1'b0;
      wake_req <= 1'b0;
      irq <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      swen_reg <= swen_next;
      ps_reg <= ps_next;
      cnt_reg <= cnt_next;
      stat_reg <= stat_next;
      ists_reg <= ists_next;
      imask_reg <= imask_next;
      sleep_d_reg <= core_evt.sleeping;
      rst_cnt_reg <= rst_cnt_next;
      reset_req <= (rst_cnt_next != 4'h0);
      wake_req <= wake_next;
      irq <= irq_next;
      prdata <= rdata_next;
      pready <= psel && !penable;
      pslverr <= err_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_off_no_count;
    @(posedge pclk) disable iff (!presetn)
    (watchdog_mode_config == 2'b00) |=> (cnt_reg == '0);
  endproperty
  a_off_no_count: assert property (p_off_no_count) else $error("counter moved while disabled");

  property p_sleep_off;
    @(posedge pclk) disable iff (!presetn)
    (watchdog_mode_config == 2'b10 && core_evt.sleeping) |=> (cnt_reg == '0);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("counter moved in sleep under mode 10");

  property p_clear_instr;
    @(posedge pclk) disable iff (!presetn)
    core_evt.clear_instr |=> (cnt_reg == '0);
  endproperty
  a_clear_instr: assert property (p_clear_instr) else $error("clear instruction did not clear counter");

  property p_startup_hold;
    @(posedge pclk) disable iff (!presetn)
    core_evt.startup_running [*2] |=> (cnt_reg == '0) && !wake_req;
  endproperty
  a_startup_hold: assert property (p_startup_hold) else $error("counter ran during start-up timer");

  property p_sleep_edge;
    @(posedge pclk) disable iff (!presetn)
    $changed(core_evt.sleeping) |=> (cnt_reg == '0);
  endproperty
  a_sleep_edge: assert property (p_sleep_edge) else $error("sleep transition did not clear counter");

  property p_wake_not_reset;
    @(posedge pclk) disable iff (!presetn)
    (timeout && core_evt.sleeping) |=> wake_req && !reset_req;
  endproperty
  a_wake_not_reset: assert property (p_wake_not_reset) else $error("sleep timeout did not wake");

  property p_awake_reset;
    @(posedge pclk) disable iff (!presetn)
    (timeout && !core_evt.sleeping) |=> reset_req [*8];
  endproperty
  a_awake_reset: assert property (p_awake_reset) else $error("awake timeout did not reset");

  property p_flags;
    @(posedge pclk) disable iff (!presetn)
    timeout |=> !stat_reg.timeout_flag && !stat_reg.watchdog_reset_indicator;
  endproperty
  a_flags: assert property (p_flags) else $error("timeout flags not recorded");

  property p_default_sel;
    @(posedge pclk) $rose(presetn) |-> (ps_reg == 5'h0B);
  endproperty
  a_default_sel: assert property (p_default_sel) else $error("reset selection is not 2 s");

  property p_always_on;
    @(posedge pclk) disable iff (!presetn)
    (watchdog_mode_config == 2'b11 && ms_tick && !clear_cnt && !timeout) |=> (cnt_reg == $past(cnt_reg) + 1'b1);
  endproperty
  a_always_on: assert property (p_always_on) else $error("counter stalled in mode 11");

  c_sleep_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_req);
  c_awake_reset: cover property (@(posedge pclk) disable iff (!presetn) $rose(reset_req));
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // wtu_top

// ==== bench/wtu_tb_top.sv ====
// Purpose: self-checking bench for the watchdog timeout unit
// Assumes: TICKS_PER_MS=2 and osc_tick every 4 cycles, so 1 ms is 8 pclk cycles
// Notes: ctrl is written while mode is 00 so no stale selection can fire early
`timescale 1ns/1ps
`include "wtu_defs.svh"
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module wtu_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_tick;
  logic reset_req, wake_req, irq, hit, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] mode, osc_cnt;
  wtu_pkg::wtu_core_evt_t evt;
  int n_mismatch = 0;
  int checks_done = 0;

  wtu_top #(.TICKS_PER_MS(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_mode_config(mode), .osc_tick(osc_tick), .core_evt(evt),
    .reset_req(reset_req), .wake_req(wake_req), .irq(irq));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // slow oscillator stand-in: one pulse every 4 cycles
  always @(posedge pclk)
  begin
    osc_cnt <= osc_cnt + 2'h1;
    osc_tick <= (osc_cnt == 2'h3);
  end

  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(nm, exp, rd)
  endtask

  // hit records any reset or wake request over n cycles
  task automatic quiet(input int n);
    hit = 1'b0;
    repeat (n)
    begin
      @(posedge pclk);
      hit = hit | reset_req | wake_req;
    end
  endtask

  task automatic wt(input bit wk, input int b);
    int n;
    n = 0;
    while (n < b && (wk ? wake_req : reset_req) !== 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    rdc("ctrl", `WTU_CTRL_OFS, 32'h00000016);
    rdc("status", `WTU_STAT_OFS, 32'h00000007);
    rdc("irq", `WTU_IRQ_OFS, 32'h00000000);
    rdc("mask", `WTU_MASK_OFS, 32'h00000000);
    rdc("count", `WTU_COUNT_OFS, 32'h00000000);
    rdc("unmapped", 12'h020, 32'h00000000);
    `CHK("slverr", 1'b1, err)
  endtask

  task automatic t_disabled();
    logic [1:0] md [3] = '{2'b00, 2'b01, 2'b10};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `WTU_CTRL_OFS, (i == 1) ? 32'h0 : 32'h1);
      evt.sleeping <= (i == 2);
      mode <= md[i];
      quiet(120);
      `CHK("off quiet", 1'b0, hit)
      rdc("off count", `WTU_COUNT_OFS, 32'h0);
      mode <= 2'b00;
      evt.sleeping <= 1'b0;
    end
  endtask

  task automatic t_awake();
    int w;
    apb(1'b1, `WTU_CTRL_OFS, 32'h1);
    apb(1'b1, `WTU_MASK_OFS, 32'h3);
    mode <= 2'b01;
    wt(1'b0, 100);
    `CHK("reset", 1'b1, reset_req)
    // switch off at once: with a 1 ms selection a second timeout would stretch the pulse
    mode <= 2'b00;
    w = 0;
    while (reset_req === 1'b1 && w < 20)
    begin
      @(posedge pclk);
      w++;
    end
    `CHK("reset len", 8, w)
    rdc("flags", `WTU_STAT_OFS, 32'h2);
    rdc("irq st", `WTU_IRQ_OFS, 32'h1);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, `WTU_IRQ_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq off", 1'b0, irq)
  endtask

  task automatic t_clear();
    logic any;
    any = 1'b0;
    apb(1'b1, `WTU_CTRL_OFS, 32'h4);
    mode <= 2'b11;
    repeat (10)
    begin
      quiet(16);
      any = any | hit;
      evt.clear_instr <= 1'b1;
      @(posedge pclk);
      evt.clear_instr <= 1'b0;
    end
    `CHK("cleared", 1'b0, any)
    rdc("flags clr", `WTU_STAT_OFS, 32'h3);
    quiet(20);
    `CHK("early", 1'b0, hit)
    wt(1'b0, 40);
    `CHK("4ms", 1'b1, reset_req)
    mode <= 2'b00;
    rdc("flags2", `WTU_STAT_OFS, 32'h2);
    apb(1'b1, `WTU_IRQ_OFS, 32'h1);
  endtask

  task automatic t_sleep();
    apb(1'b1, `WTU_CTRL_OFS, 32'h0);
    evt.sleeping <= 1'b1;
    mode <= 2'b11;
    wt(1'b1, 100);
    `CHK("wake", 1'b1, wake_req)
    `CHK("no rst", 1'b0, reset_req)
    rdc("slp flags", `WTU_STAT_OFS, 32'h0);
    rdc("irq slp", `WTU_IRQ_OFS, 32'h2);
    evt.sleeping <= 1'b0;
    evt.startup_running <= 1'b1;
    quiet(100);
    `CHK("startup", 1'b0, hit)
    rdc("startup count", `WTU_COUNT_OFS, 32'h0);
    evt.startup_running <= 1'b0;
    evt.osc_fail <= 1'b1;
    quiet(100);
    `CHK("osc fail", 1'b0, hit)
    evt.osc_fail <= 1'b0;
    mode <= 2'b10;
    wt(1'b0, 100);
    `CHK("rst after", 1'b1, reset_req)
    mode <= 2'b00;
    apb(1'b1, `WTU_IRQ_OFS, 32'h3);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = 2'b00;
    evt = '0;
    osc_cnt = 2'h0;
    osc_tick = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    t_disabled();
    t_awake();
    t_clear();
    t_sleep();
    apb(1'b1, `WTU_CTRL_OFS, 32'h4);
    mode <= 2'b11;
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    mode <= 2'b00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    wrap_up();
  end
endmodule // wtu_tb_top
